/* File: integer_multiply_divide_unit.sv */
// Notes on behaviour
// - Pair and accumulate ops: 16-bit latency 3 repeat 2, 32-bit latency 4 repeat 3.
// - Direct-write multiply: 3/2 with 1 stall, or 4/3 with 2 stalls.
// - Divides take 36 clocks, block reissue for 36, never stall.
// - All counts are pipeline clocks.
// - Pair products and divides land in the upper and bottom result registers.
// - Two moves copy the upper or bottom result into a chosen register.
// - Direct-write multiply sends its low product word straight to the register file.
// - Accumulate-add adds the product to the 64-bit pair atomically.
// - Accumulate-deduct subtracts the product from the 64-bit pair atomically.
// - A new multiply or divide is taken once the repeat interval lapses, results pending or not.
// - Operand size is detected per op, choosing short or long timing.
// - Interlocks hold the pipeline on unfinished results or overrun.
// - The unit runs beside the pipeline; only listed stalls hold it.
// - Upper and bottom results are 32 bits each, one 64-bit accumulator.
`timescale 1ns/1ps
`default_nettype none
module integer_multiply_divide_unit #(
    parameter int unsigned LINE_STAGES = muldiv_pkg::LINE_DEPTH
) (
    // Clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          sys_rst_i,
    // Issue from the pipeline
    input  wire muldiv_pkg::issue_type         issue_i,
    output logic                               issue_ready_o,
    output logic                               move_ready_o,
    output logic                               stall_o,
    // Register file write
    output muldiv_pkg::gpr_write_type          gpr_wr_o,
    // Result pair
    output logic [muldiv_pkg::DATA_W-1:0]      upper_result_o,
    output logic [muldiv_pkg::DATA_W-1:0]      bottom_result_o
);
    import muldiv_pkg::*;

    localparam int unsigned SLOT_W = $clog2(LINE_STAGES);

    if (LINE_STAGES < LAT_LONG) begin : g_bad_stages
        $error("LINE_STAGES must cover the longest multiply latency");
    end

    // ***************************************************************
    // Helpers
    // ***************************************************************
    function automatic logic is_short_operand(input logic [DATA_W-1:0] v, input logic sgn);
        logic ext;
        ext = sgn & v[HALF_W-1];
        is_short_operand = (v[DATA_W-1:HALF_W] == {HALF_W{ext}});
    endfunction

    function automatic logic [ACC_W-1:0] full_product(input logic [DATA_W-1:0] a,
                                                      input logic [DATA_W-1:0] b,
                                                      input logic sgn);
        logic signed [DATA_W:0]     a_x;
        logic signed [DATA_W:0]     b_x;
        logic signed [2*DATA_W+1:0] p;
        a_x = $signed({sgn & a[DATA_W-1], a});
        b_x = $signed({sgn & b[DATA_W-1], b});
        p = a_x * b_x;
        full_product = p[ACC_W-1:0];
    endfunction

    // ***************************************************************
    // Registers and wires
    // ***************************************************************
    logic [DATA_W-1:0]  upper_r;
    logic [DATA_W-1:0]  bottom_r;
    logic [CNT_W-1:0]   rep_cnt_r;
    logic [CNT_W-1:0]   rep_cnt_nxt;
    logic [CNT_W-1:0]   stall_cnt_r;
    logic [CNT_W-1:0]   stall_cnt_nxt;
    logic               issue_ready_r;
    logic               move_ready_r;
    logic               stall_r;
    gpr_write_type      gpr_wr_r;

    logic               is_line_op;
    logic               is_div_op;
    logic               is_move_op;
    logic               op_signed;
    acc_mode_type       op_mode;
    logic               op_short;
    logic               arith_fire;
    logic               line_fire;
    logic               div_fire;
    logic               move_fire;
    logic [CNT_W-1:0]   op_rep;
    logic [CNT_W-1:0]   op_stall;
    logic [SLOT_W-1:0]  op_slot;
    line_entry_type     line_ins;
    line_entry_type     line_out;
    logic               line_held;
    logic               div_busy;
    logic               div_done;
    logic [DATA_W-1:0]  div_quo;
    logic [DATA_W-1:0]  div_rem;
    logic               pending_after;

    // ***************************************************************
    // Decode
    // ***************************************************************
    always_comb begin
        is_line_op = 1'b0;
        is_div_op  = 1'b0;
        is_move_op = 1'b0;
        op_signed  = 1'b0;
        op_mode    = ACC_LOAD;
        case (issue_i.op)
            OP_PRODUCT_TO_PAIR: begin
                is_line_op = 1'b1;
                op_signed  = 1'b1;
            end
            OP_UNSIGNED_PRODUCT_TO_PAIR: begin
                is_line_op = 1'b1;
            end
            OP_ACCUMULATE_PRODUCT_ADD: begin
                is_line_op = 1'b1;
                op_signed  = 1'b1;
                op_mode    = ACC_ADD;
            end
            OP_UNSIGNED_ACCUMULATE_ADD: begin
                is_line_op = 1'b1;
                op_mode    = ACC_ADD;
            end
            OP_ACCUMULATE_PRODUCT_DEDUCT: begin
                is_line_op = 1'b1;
                op_signed  = 1'b1;
                op_mode    = ACC_DEDUCT;
            end
            OP_UNSIGNED_ACCUMULATE_DEDUCT: begin
                is_line_op = 1'b1;
                op_mode    = ACC_DEDUCT;
            end
            OP_PRODUCT_DIRECT_WRITE: begin
                is_line_op = 1'b1;
                op_signed  = 1'b1;
                op_mode    = ACC_DIRECT;
            end
            OP_SIGNED_QUOTIENT_OP: begin
                is_div_op = 1'b1;
                op_signed = 1'b1;
            end
            OP_UNSIGNED_QUOTIENT_OP: begin
                is_div_op = 1'b1;
            end
            OP_READ_UPPER_RESULT, OP_READ_BOTTOM_RESULT: begin
                is_move_op = 1'b1;
            end
            default: begin
                is_line_op = 1'b0;
            end
        endcase
    end

    // Size is judged on both operands, no software hint needed
    assign op_short = is_short_operand(issue_i.src_a, op_signed)
                    & is_short_operand(issue_i.src_b, op_signed);

    // ***************************************************************
    // Acceptance and per-op timing
    // ***************************************************************
    assign arith_fire = issue_i.valid & issue_ready_r & (is_line_op | is_div_op);
    assign line_fire  = arith_fire & is_line_op;
    assign div_fire   = arith_fire & is_div_op;
    // Moves wait until nothing is in flight
    assign move_fire  = issue_i.valid & move_ready_r & is_move_op;

    always_comb begin
        if (is_div_op) begin
            op_rep  = CNT_W'(DIV_REP);
            op_slot = '0;
        end else if (op_short) begin
            op_rep  = CNT_W'(REP_SHORT);
            op_slot = SLOT_W'(LINE_STAGES - LAT_SHORT);
        end else begin
            op_rep  = CNT_W'(REP_LONG);
            op_slot = SLOT_W'(LINE_STAGES - LAT_LONG);
        end
        if (is_line_op && op_mode == ACC_DIRECT) begin
            op_stall = op_short ? CNT_W'(STALL_SHORT) : CNT_W'(STALL_LONG);
        end else begin
            op_stall = CNT_RESET;
        end
    end

    always_comb begin
        rep_cnt_nxt = rep_cnt_r;
        if (arith_fire) begin
            rep_cnt_nxt = op_rep - 6'h01;
        end else if (rep_cnt_r != CNT_RESET) begin
            rep_cnt_nxt = rep_cnt_r - 6'h01;
        end
    end

    always_comb begin
        stall_cnt_nxt = stall_cnt_r;
        if (line_fire) begin
            stall_cnt_nxt = op_stall;
        end else if (stall_cnt_r != CNT_RESET) begin
            stall_cnt_nxt = stall_cnt_r - 6'h01;
        end
    end

    // Overrun guard: issue_ready stays low for one clock less than the repeat interval
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rep_cnt_r     <= CNT_RESET;
            issue_ready_r <= 1'b1;
        end else begin
            rep_cnt_r     <= rep_cnt_nxt;
            issue_ready_r <= (rep_cnt_nxt == CNT_RESET);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            stall_cnt_r <= CNT_RESET;
            stall_r     <= 1'b0;
        end else begin
            stall_cnt_r <= stall_cnt_nxt;
            stall_r     <= (stall_cnt_nxt != CNT_RESET);
        end
    end

    // Anything still owed to the pair after this edge blocks moves
    assign pending_after = line_held | line_fire | div_fire | (div_busy & ~div_done);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            move_ready_r <= 1'b1;
        end else begin
            move_ready_r <= ~pending_after;
        end
    end

    // ***************************************************************
    // Multiply line
    // ***************************************************************
    always_comb begin
        line_ins.valid   = line_fire;
        line_ins.mode    = op_mode;
        line_ins.dest    = issue_i.dest;
        line_ins.product = full_product(issue_i.src_a, issue_i.src_b, op_signed);
    end

    product_delay_line #(
        .DEPTH     (LINE_STAGES)
    ) u_line (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ins_i     (line_ins),
        .slot_i    (op_slot),
        .out_o     (line_out),
        .held_o    (line_held)
    );

    // ***************************************************************
    // Divider
    // ***************************************************************
    divide_engine u_div (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .start_i     (div_fire),
        .signed_i    (op_signed),
        .dividend_i  (issue_i.src_a),
        .divisor_i   (issue_i.src_b),
        .busy_o      (div_busy),
        .done_o      (div_done),
        .quotient_o  (div_quo),
        .remainder_o (div_rem)
    );

    // ***************************************************************
    // Result pair
    // ***************************************************************
    // Accumulate reads the pair at retire time; ops retire in issue
    // order, so chained accumulates see each other's sums.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            upper_r  <= RESULT_RESET;
            bottom_r <= RESULT_RESET;
        end else if (div_done) begin
            upper_r  <= div_rem;
            bottom_r <= div_quo;
        end else if (line_out.valid) begin
            case (line_out.mode)
                ACC_LOAD: begin
                    {upper_r, bottom_r} <= line_out.product;
                end
                ACC_ADD: begin
                    {upper_r, bottom_r} <= {upper_r, bottom_r} + line_out.product;
                end
                ACC_DEDUCT: begin
                    {upper_r, bottom_r} <= {upper_r, bottom_r} - line_out.product;
                end
                default: begin
                    upper_r  <= upper_r;
                    bottom_r <= bottom_r;
                end
            endcase
        end
    end

    // ***************************************************************
    // Register file writes
    // ***************************************************************
    // A move only fires with the unit drained, so it never meets a retire
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            gpr_wr_r <= '0;
        end else if (line_out.valid && line_out.mode == ACC_DIRECT) begin
            gpr_wr_r.valid <= 1'b1;
            gpr_wr_r.dest  <= line_out.dest;
            gpr_wr_r.data  <= line_out.product[DATA_W-1:0];
        end else if (move_fire) begin
            gpr_wr_r.valid <= 1'b1;
            gpr_wr_r.dest  <= issue_i.dest;
            gpr_wr_r.data  <= (issue_i.op == OP_READ_UPPER_RESULT) ? upper_r : bottom_r;
        end else begin
            gpr_wr_r.valid <= 1'b0;
        end
    end

    assign issue_ready_o   = issue_ready_r;
    assign move_ready_o    = move_ready_r;
    assign stall_o         = stall_r;
    assign gpr_wr_o        = gpr_wr_r;
    assign upper_result_o  = upper_r;
    assign bottom_result_o = bottom_r;

endmodule
`default_nettype wire

/* File: muldiv_pkg.sv */
`default_nettype none
package muldiv_pkg;

    // ***************************************************************
    // Widths
    // ***************************************************************
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned HALF_W    = 16;
    localparam int unsigned ACC_W     = 64;
    localparam int unsigned REG_IDX_W = 5;
    localparam int unsigned CNT_W     = 6;

    // ***************************************************************
    // Timing in pipeline clocks
    // ***************************************************************
    localparam int unsigned LAT_SHORT       = 3;
    localparam int unsigned LAT_LONG        = 4;
    localparam int unsigned REP_SHORT       = 2;
    localparam int unsigned REP_LONG        = 3;
    localparam int unsigned STALL_SHORT     = 1;
    localparam int unsigned STALL_LONG      = 2;
    localparam int unsigned DIV_LAT         = 36;
    localparam int unsigned DIV_REP         = 36;
    localparam int unsigned DIV_STEPS       = 32;
    localparam int unsigned LINE_DEPTH      = 4;

    // ***************************************************************
    // Values after reset
    // ***************************************************************
    localparam logic [DATA_W-1:0] RESULT_RESET = 32'h0000_0000;
    localparam logic [CNT_W-1:0]  CNT_RESET    = 6'h00;

    // ***************************************************************
    // Operations
    // ***************************************************************
    typedef enum logic [3:0] {
        OP_NONE                       = 4'h0,
        OP_PRODUCT_TO_PAIR            = 4'h1,
        OP_UNSIGNED_PRODUCT_TO_PAIR   = 4'h2,
        OP_ACCUMULATE_PRODUCT_ADD     = 4'h3,
        OP_UNSIGNED_ACCUMULATE_ADD    = 4'h4,
        OP_ACCUMULATE_PRODUCT_DEDUCT  = 4'h5,
        OP_UNSIGNED_ACCUMULATE_DEDUCT = 4'h6,
        OP_PRODUCT_DIRECT_WRITE       = 4'h7,
        OP_SIGNED_QUOTIENT_OP         = 4'h8,
        OP_UNSIGNED_QUOTIENT_OP       = 4'h9,
        OP_READ_UPPER_RESULT          = 4'hA,
        OP_READ_BOTTOM_RESULT         = 4'hB
    } md_op_type;

    typedef enum logic [1:0] {
        ACC_LOAD   = 2'h0,
        ACC_ADD    = 2'h1,
        ACC_DEDUCT = 2'h2,
        ACC_DIRECT = 2'h3
    } acc_mode_type;

    typedef enum logic [1:0] {
        DIV_IDLE = 2'h1,
        DIV_RUN  = 2'h2
    } div_state_type;

    // ***************************************************************
    // Carriers
    // ***************************************************************
    typedef struct packed {
        logic                 valid;
        md_op_type            op;
        logic [DATA_W-1:0]    src_a;
        logic [DATA_W-1:0]    src_b;
        logic [REG_IDX_W-1:0] dest;
    } issue_type;

    typedef struct packed {
        logic                 valid;
        logic [REG_IDX_W-1:0] dest;
        logic [DATA_W-1:0]    data;
    } gpr_write_type;

    typedef struct packed {
        logic                 valid;
        acc_mode_type         mode;
        logic [REG_IDX_W-1:0] dest;
        logic [ACC_W-1:0]     product;
    } line_entry_type;

endpackage
`default_nettype wire

/* File: product_delay_line.sv */
`timescale 1ns/1ps
`default_nettype none
module product_delay_line #(
    parameter int unsigned DEPTH = muldiv_pkg::LINE_DEPTH
) (
    // Clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         sys_rst_i,
    // Insertion
    input  wire muldiv_pkg::line_entry_type   ins_i,
    input  wire logic [$clog2(DEPTH)-1:0]     slot_i,
    // Exit
    output muldiv_pkg::line_entry_type        out_o,
    output logic                              held_o
);
    import muldiv_pkg::*;

    // ***************************************************************
    // Stages
    // ***************************************************************
    line_entry_type stage_r [DEPTH];

    if (DEPTH < 2) begin : g_bad_depth
        $error("product_delay_line needs at least two stages");
    end

    // Entry enters at a slot chosen so it leaves after its latency
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                stage_r[i] <= '0;
            end
        end else begin
            stage_r[0] <= '0;
            for (int i = 1; i < DEPTH; i++) begin
                stage_r[i] <= stage_r[i-1];
            end
            if (ins_i.valid) begin
                stage_r[slot_i] <= ins_i;
            end
        end
    end

    assign out_o = stage_r[DEPTH-1];

    always_comb begin
        held_o = 1'b0;
        for (int i = 0; i < DEPTH - 1; i++) begin
            held_o = held_o | stage_r[i].valid;
        end
    end

endmodule
`default_nettype wire

/* File: divide_engine.sv */
`timescale 1ns/1ps
`default_nettype none
module divide_engine (
    // Clock and reset
    input  wire logic                             clk_i,
    input  wire logic                             sys_rst_i,
    // Request
    input  wire logic                             start_i,
    input  wire logic                             signed_i,
    input  wire logic [muldiv_pkg::DATA_W-1:0]    dividend_i,
    input  wire logic [muldiv_pkg::DATA_W-1:0]    divisor_i,
    // Result
    output logic                                  busy_o,
    output logic                                  done_o,
    output logic [muldiv_pkg::DATA_W-1:0]         quotient_o,
    output logic [muldiv_pkg::DATA_W-1:0]         remainder_o
);
    import muldiv_pkg::*;

    function automatic logic [DATA_W-1:0] magnitude(input logic [DATA_W-1:0] v, input logic neg);
        magnitude = neg ? (~v + 32'h0000_0001) : v;
    endfunction

    div_state_type       state_r;
    logic [CNT_W-1:0]    cnt_r;
    logic [DATA_W-1:0]   rem_r;
    logic [DATA_W-1:0]   quo_r;
    logic [DATA_W-1:0]   dvs_r;
    logic                neg_q_r;
    logic                neg_r_r;
    logic [DATA_W:0]     shifted;
    logic [DATA_W:0]     diff;

    assign shifted = {rem_r, quo_r[DATA_W-1]};
    assign diff    = shifted - {1'b0, dvs_r};

    // ***************************************************************
    // Sequencer: one quotient bit per clock, then idle out the count
    // ***************************************************************
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_r <= DIV_IDLE;
            cnt_r   <= CNT_RESET;
        end else begin
            case (state_r)
                DIV_IDLE: begin
                    if (start_i) begin
                        state_r <= DIV_RUN;
                        cnt_r   <= CNT_RESET;
                    end
                end
                DIV_RUN: begin
                    if (cnt_r == CNT_W'(DIV_LAT - 1)) begin
                        state_r <= start_i ? DIV_RUN : DIV_IDLE;
                    end
                    cnt_r <= done_o ? CNT_RESET : cnt_r + 6'h01;
                end
                default: begin
                    state_r <= DIV_IDLE;
                end
            endcase
        end
    end

    // ***************************************************************
    // Restoring datapath on magnitudes
    // ***************************************************************
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rem_r   <= RESULT_RESET;
            quo_r   <= RESULT_RESET;
            dvs_r   <= RESULT_RESET;
            neg_q_r <= 1'b0;
            neg_r_r <= 1'b0;
        end else if (start_i && (!busy_o || done_o)) begin
            rem_r   <= RESULT_RESET;
            quo_r   <= magnitude(dividend_i, signed_i & dividend_i[DATA_W-1]);
            dvs_r   <= magnitude(divisor_i, signed_i & divisor_i[DATA_W-1]);
            neg_q_r <= signed_i & (dividend_i[DATA_W-1] ^ divisor_i[DATA_W-1]);
            neg_r_r <= signed_i & dividend_i[DATA_W-1];
        end else if (state_r == DIV_RUN && cnt_r < CNT_W'(DIV_STEPS)) begin
            if (!diff[DATA_W]) begin
                rem_r <= diff[DATA_W-1:0];
                quo_r <= {quo_r[DATA_W-2:0], 1'b1};
            end else begin
                rem_r <= shifted[DATA_W-1:0];
                quo_r <= {quo_r[DATA_W-2:0], 1'b0};
            end
        end
    end

    assign busy_o      = (state_r == DIV_RUN);
    assign done_o      = (state_r == DIV_RUN) && (cnt_r == CNT_W'(DIV_LAT - 1));
    assign quotient_o  = magnitude(quo_r, neg_q_r);
    assign remainder_o = magnitude(rem_r, neg_r_r);

endmodule
`default_nettype wire

/* File: muldiv_checker_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module muldiv_checker import muldiv_pkg::*; (
    input wire logic              clk_i,
    input wire logic              sys_rst_i,
    input wire issue_type         issue_i,
    input wire logic              issue_ready_o,
    input wire logic              move_ready_o,
    input wire logic              stall_o,
    input wire gpr_write_type     gpr_wr_o,
    input wire logic [DATA_W-1:0] upper_result_o,
    input wire logic [DATA_W-1:0] bottom_result_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic sg, sh, tk, dv, dw;
    always_comb begin
        sg = issue_i.op inside {OP_PRODUCT_TO_PAIR, OP_ACCUMULATE_PRODUCT_ADD,
            OP_ACCUMULATE_PRODUCT_DEDUCT, OP_PRODUCT_DIRECT_WRITE, OP_SIGNED_QUOTIENT_OP};
        sh = (issue_i.src_a[31:16] == {16{sg & issue_i.src_a[15]}})
            && (issue_i.src_b[31:16] == {16{sg & issue_i.src_b[15]}});
        tk = issue_i.valid && issue_ready_o && (issue_i.op inside {[4'h1:4'h9]});
        dv = issue_i.op inside {OP_SIGNED_QUOTIENT_OP, OP_UNSIGNED_QUOTIENT_OP};
        dw = issue_i.op == OP_PRODUCT_DIRECT_WRITE;
    end
    AST_DIV_REPEAT: assert property (tk && dv |=> !issue_ready_o ##34 !issue_ready_o
        ##1 issue_ready_o) else $error("divide reissue interval wrong");
    AST_NO_STALL: assert property (tk && !dw |=> !stall_o)
        else $error("stall without direct write");
    AST_SHORT_STALL: assert property (tk && dw && sh |=> stall_o ##1 !stall_o)
        else $error("short direct stall wrong");
    AST_LONG_STALL: assert property (tk && dw && !sh |=> stall_o [*2] ##1 !stall_o)
        else $error("long direct stall wrong");
    AST_SHORT_REPEAT: assert property (tk && !dv && sh |=> !issue_ready_o
        ##1 issue_ready_o) else $error("short reissue interval wrong");
    AST_LONG_REPEAT: assert property (tk && !dv && !sh |=> !issue_ready_o [*2]
        ##1 issue_ready_o) else $error("long reissue interval wrong");
    AST_MOVE_HOLD: assert property (tk |=> !move_ready_o)
        else $error("move allowed with result pending");
    AST_DIRECT_WR: assert property (tk && dw && sh |-> ##4 gpr_wr_o.valid &&
        gpr_wr_o.dest == $past(issue_i.dest, 4)) else $error("direct write late or misdirected");
    AST_MOVE_READ: assert property (issue_i.valid && move_ready_o &&
        issue_i.op == OP_READ_UPPER_RESULT |=> gpr_wr_o.valid &&
        gpr_wr_o.data == $past(upper_result_o)) else $error("upper move wrong");
endmodule
bind integer_multiply_divide_unit muldiv_checker u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .issue_i(issue_i), .issue_ready_o(issue_ready_o), .move_ready_o(move_ready_o),
    .stall_o(stall_o), .gpr_wr_o(gpr_wr_o), .upper_result_o(upper_result_o),
    .bottom_result_o(bottom_result_o));
`default_nettype wire

/* File: pipeline_issuer.sv */
`timescale 1ns/1ps
`default_nettype none
module pipeline_issuer import muldiv_pkg::*; (
    input  wire logic clk_i,
    input  wire logic issue_ready_i,
    input  wire logic move_ready_i,
    output issue_type issue_o
);
    initial issue_o = '0;
    // Offer stays up until its ready is seen at a rising edge
    task automatic send(input md_op_type op, input logic [31:0] a, b, input logic [4:0] d);
        int n;
        @(negedge clk_i);
        issue_o <= '{1'b1, op, a, b, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (!((op inside {OP_READ_UPPER_RESULT, OP_READ_BOTTOM_RESULT}) ?
            move_ready_i : issue_ready_i) && n < 60);
    endtask
    // Released fields flip so stale values are never mistaken for held ones
    task automatic idle();
        @(negedge clk_i);
        issue_o <= '{1'b0, OP_NONE, ~issue_o.src_a, ~issue_o.src_b, ~issue_o.dest};
    endtask
endmodule
`default_nettype wire

/* File: integer_multiply_divide_unit_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module integer_multiply_divide_unit_tb;
    import muldiv_pkg::*;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, rdy, mrdy, stl;
    issue_type iss;
    gpr_write_type gw, lw;
    logic [31:0] up, bt;
    logic [63:0] acc;
    int error_cnt = 0, n_checks = 0;
    always #2.5 clk_i = ~clk_i;
    pipeline_issuer PIPE (.clk_i(clk_i), .issue_ready_i(rdy), .move_ready_i(mrdy), .issue_o(iss));
    integer_multiply_divide_unit DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .issue_i(iss),
        .issue_ready_o(rdy), .move_ready_o(mrdy), .stall_o(stl), .gpr_wr_o(gw),
        .upper_result_o(up), .bottom_result_o(bt));
    always @(posedge clk_i) if (gw.valid) lw <= gw;
    function automatic logic [63:0] prod(input logic s, input logic [31:0] a, b);
        return s ? {{32{a[31]}}, a} * {{32{b[31]}}, b} : {32'h0, a} * {32'h0, b};
    endfunction
    task automatic chk(input logic [63:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task automatic run(input md_op_type op, input logic [31:0] a, b, input logic [4:0] d,
        input int w);
        PIPE.send(op, a, b, d);
        PIPE.idle();
        repeat (w) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic t_reset();
        chk({up, bt}, 64'h0);
        chk({61'h0, rdy, mrdy, stl}, 64'h6);
    endtask
    task automatic t_pair();
        run(OP_PRODUCT_TO_PAIR, 32'hFFFF_FFFD, 32'h7, 5'h1, 5);
        chk({up, bt}, 64'hFFFF_FFFF_FFFF_FFEB);
        run(OP_UNSIGNED_PRODUCT_TO_PAIR, 32'hFFFF_FFFF, 32'h2, 5'h1, 5);
        acc = 64'h1_FFFF_FFFE;
        chk({up, bt}, acc);
    endtask
    // Four accumulates offered back to back; each waits only on reissue
    task automatic t_accum();
        md_op_type ops[4] = '{OP_ACCUMULATE_PRODUCT_ADD, OP_UNSIGNED_ACCUMULATE_ADD,
            OP_ACCUMULATE_PRODUCT_DEDUCT, OP_UNSIGNED_ACCUMULATE_DEDUCT};
        logic [31:0] a[4] = '{32'h1_2345, 32'h8000_0000, 32'hFFFF_FFF0, 32'h7};
        logic [31:0] b[4] = '{32'h10, 32'h2, 32'h3, 32'h9};
        for (int i = 0; i < 4; i++) begin
            PIPE.send(ops[i], a[i], b[i], 5'h2);
            acc = (i < 2) ? acc + prod(!i[0], a[i], b[i]) : acc - prod(!i[0], a[i], b[i]);
        end
        run(OP_NONE, 32'h0, 32'h0, 5'h0, 8);
        chk({up, bt}, acc);
    endtask
    task automatic t_direct();
        run(OP_PRODUCT_DIRECT_WRITE, 32'h6, 32'hFFFF_FFFC, 5'h9, 6);
        chk({lw.dest, lw.data}, {5'h9, 32'hFFFF_FFE8});
        run(OP_PRODUCT_DIRECT_WRITE, 32'h1_0000, 32'h3, 5'h11, 7);
        chk({lw.dest, lw.data}, {5'h11, 32'h3_0000});
        chk({up, bt}, acc);
    endtask
    task automatic t_move();
        run(OP_READ_UPPER_RESULT, 32'h0, 32'h0, 5'h3, 2);
        chk({lw.dest, lw.data}, {5'h3, acc[63:32]});
        run(OP_READ_BOTTOM_RESULT, 32'h0, 32'h0, 5'h4, 2);
        chk({lw.dest, lw.data}, {5'h4, acc[31:0]});
    endtask
    task automatic t_divide();
        PIPE.send(OP_SIGNED_QUOTIENT_OP, 32'hFFFF_FFEF, 32'h5, 5'h0);
        run(OP_UNSIGNED_QUOTIENT_OP, 32'h64, 32'h7, 5'h0, 1);
        chk({up, bt}, {32'hFFFF_FFFE, 32'hFFFF_FFFD});
        repeat (36) @(negedge clk_i);
        chk({up, bt}, {32'h2, 32'hE});
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #(5 * 3000);
        error_cnt++;
        final_report();
    end
    initial begin
        repeat (10) @(negedge clk_i);
        sys_rst_i = 1'b0;
        t_reset();
        t_pair();
        t_accum();
        t_direct();
        t_move();
        t_divide();
        final_report();
    end
endmodule
`default_nettype wire
